// *** rtl/boot_lock_defs.vh ***
// constants for the boot lock and self-programming control block
`ifndef BOOT_LOCK_DEFS_VH
`define BOOT_LOCK_DEFS_VH
`define OFS_SPMCS 8'h00
`define OFS_LOCKS 8'h04
`define OFS_FUSE 8'h08
`define OFS_STATUS 8'h0C
`define OFS_CMD 8'h10
`define SPMCS_RESET 8'h00
`define BIT_IRQ_EN 7
`define BIT_BUSY 6
`define BIT_RSVD 5
`define BIT_REEN 4
`define BIT_LOCKSET 3
`define BIT_PGWRT 2
`define BIT_PGERS 1
`define BIT_ARM 0
`define ARM_WINDOW_NS 32
`define CLK_PERIOD_NS 8
`define ARM_CYCLES 3'h4
`define LOCKS_RESET 8'hFF
`define OP_DONE_CYCLES 16
`endif

// *** rtl/lock_field_decode.v ***
// decodes one two-bit boot lock field into its restrictions
`timescale 1ns/10ps
module lock_field_decode (
    input wire [1:0] field,
    output wire write_block,
    output wire read_block
);
    // 11 mode1, 10 mode2, 00 mode3, 01 mode4
    // low bit programmed (modes 2,3) stops writes
    assign write_block = ~field[0];
    // high bit programmed (modes 3,4) stops cross-section reads
    assign read_block = ~field[1];
endmodule

// *** rtl/boot_lock_self_program_ctrl.v ***
// boot lock protection and self-programming control with axi4-lite access
`timescale 1ns/10ps
`include "boot_lock_defs.vh"
module boot_lock_self_program_ctrl #(
    parameter OP_CYCLES = `OP_DONE_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire store_program_insn,
    input wire insn_target_boot,
    input wire insn_target_halting,
    input wire [7:0] insn_lock_data,
    input wire exec_from_boot,
    input wire load_program_req,
    input wire load_target_boot,
    input wire vectors_in_boot,
    input wire global_irq_flag,
    input wire boot_reset_fuse_n,
    input wire chip_erase,
    input wire ext_lock_write,
    input wire [7:0] ext_lock_data,
    output reg flash_ready_irq,
    output reg cpu_halt,
    output reg concurrent_read_block,
    output reg load_program_deny,
    output reg store_program_deny,
    output reg irq_mask,
    output reg reset_to_boot,
    output reg [1:0] spm_op_start,
    output reg page_load_strobe
);
    localparam ST_IDLE = 3'b001;
    localparam ST_ARMED = 3'b010;
    localparam ST_BUSY = 3'b100;
    reg [2:0] state_reg;
    reg [7:0] ctrl_reg;
    reg [2:0] arm_cnt_reg;
    reg [7:0] busy_cnt_reg;
    reg busy_halt_reg;
    reg [7:0] lock_reg;
    reg [7:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg aw_have_reg;
    reg w_have_reg;
    wire [1:0] app_lock_field = lock_reg[1:0];
    wire [1:0] boot_lock_field = lock_reg[3:2];
    wire app_wr_blk, app_rd_blk, boot_wr_blk, boot_rd_blk;
    lock_field_decode u_app (
        .field(app_lock_field),
        .write_block(app_wr_blk),
        .read_block(app_rd_blk)
    );
    lock_field_decode u_boot (
        .field(boot_lock_field),
        .write_block(boot_wr_blk),
        .read_block(boot_rd_blk)
    );
    wire concurrent_region_busy = ctrl_reg[`BIT_BUSY];
    wire store_program_arm = ctrl_reg[`BIT_ARM];
    wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire ctrl_wr = do_write && aw_addr_reg == `OFS_SPMCS && w_strb_reg[0];
    wire lock_wr = do_write && aw_addr_reg == `OFS_LOCKS && w_strb_reg[0];
    wire [4:0] cmd_lo = w_data_reg[4:0];
    // only the documented command codes arm; others ignored
    wire cmd_ok = cmd_lo == 5'h11 || cmd_lo == 5'h09 || cmd_lo == 5'h05 ||
        cmd_lo == 5'h03 || cmd_lo == 5'h01;
    // store-program allowed only from boot code
    wire insn_fire = store_program_insn && state_reg == ST_ARMED && exec_from_boot;
    // general lock modes deliberately not an input here
    wire target_wr_blk = insn_target_boot ? boot_wr_blk : app_wr_blk;
    wire is_prog = ctrl_reg[`BIT_PGWRT] | ctrl_reg[`BIT_PGERS];
    wire is_load = !is_prog && !ctrl_reg[`BIT_LOCKSET] && !ctrl_reg[`BIT_REEN];
    wire cross_rd_blk = load_target_boot ? (!exec_from_boot && boot_rd_blk)
        : (exec_from_boot && app_rd_blk);
    wire conc_target = !insn_target_halting;
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            ctrl_reg <= `SPMCS_RESET;
            arm_cnt_reg <= 3'h0;
            busy_cnt_reg <= 8'h00;
            busy_halt_reg <= 1'b0;
            spm_op_start <= 2'b00;
            page_load_strobe <= 1'b0;
        end else begin
            spm_op_start <= 2'b00;
            page_load_strobe <= 1'b0;
            if (ctrl_wr)
                ctrl_reg[`BIT_IRQ_EN] <= w_data_reg[`BIT_IRQ_EN];
            case (state_reg)
                ST_IDLE: begin
                    if (ctrl_wr && cmd_ok && w_data_reg[`BIT_ARM]) begin
                        ctrl_reg[4:0] <= cmd_lo;
                        arm_cnt_reg <= `ARM_CYCLES;
                        state_reg <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (insn_fire) begin
                        if (ctrl_reg[`BIT_REEN]) begin
                            ctrl_reg[`BIT_BUSY] <= 1'b0;
                            ctrl_reg[4:0] <= 5'h00;
                            state_reg <= ST_IDLE;
                        end else if (ctrl_reg[`BIT_LOCKSET]) begin
                            ctrl_reg[4:0] <= 5'h00;
                            state_reg <= ST_IDLE;
                        end else if (is_prog && !target_wr_blk) begin
                            spm_op_start <= {ctrl_reg[`BIT_PGWRT], ctrl_reg[`BIT_PGERS]};
                            busy_cnt_reg <= OP_CYCLES[7:0];
                            busy_halt_reg <= insn_target_halting;
                            if (conc_target)
                                ctrl_reg[`BIT_BUSY] <= 1'b1;
                            state_reg <= ST_BUSY;
                        end else if (is_load) begin
                            page_load_strobe <= 1'b1;
                            ctrl_reg[`BIT_BUSY] <= 1'b0;
                            ctrl_reg[4:0] <= 5'h00;
                            state_reg <= ST_IDLE;
                        end else begin
                            ctrl_reg[4:0] <= 5'h00;
                            state_reg <= ST_IDLE;
                        end
                    end else if (arm_cnt_reg == 3'h1) begin
                        ctrl_reg[4:0] <= 5'h00;
                        state_reg <= ST_IDLE;
                    end else begin
                        arm_cnt_reg <= arm_cnt_reg - 3'h1;
                    end
                end
                ST_BUSY: begin
                    // arm stays high until the operation ends
                    if (busy_cnt_reg == 8'h01) begin
                        ctrl_reg[4:0] <= 5'h00;
                        busy_halt_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else begin
                        busy_cnt_reg <= busy_cnt_reg - 8'h01;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
    // lock bits: programming only clears bits, erase returns them to ones
    always @(posedge aclk) begin
        if (!aresetn) begin
            lock_reg <= `LOCKS_RESET;
        end else if (chip_erase) begin
            lock_reg <= `LOCKS_RESET;
        end else begin
            if (ext_lock_write)
                lock_reg <= lock_reg & ext_lock_data;
            else if (insn_fire && ctrl_reg[`BIT_LOCKSET])
                lock_reg <= lock_reg & insn_lock_data;
        end
    end
    // outputs registered
    always @(posedge aclk) begin
        if (!aresetn) begin
            flash_ready_irq <= 1'b0;
            cpu_halt <= 1'b0;
            concurrent_read_block <= 1'b0;
            load_program_deny <= 1'b0;
            store_program_deny <= 1'b0;
            irq_mask <= 1'b0;
            reset_to_boot <= 1'b0;
        end else begin
            flash_ready_irq <= ctrl_reg[`BIT_IRQ_EN] && global_irq_flag &&
                !store_program_arm;
            cpu_halt <= state_reg == ST_BUSY && busy_halt_reg;
            concurrent_read_block <= concurrent_region_busy ||
                (state_reg == ST_BUSY && busy_halt_reg);
            load_program_deny <= load_program_req &&
                (cross_rd_blk || (!load_target_boot && concurrent_region_busy));
            store_program_deny <= store_program_insn && state_reg == ST_ARMED &&
                is_prog && target_wr_blk;
            irq_mask <= exec_from_boot ? (!vectors_in_boot && boot_rd_blk)
                : (vectors_in_boot && app_rd_blk);
            // fuse is a pin only; no register path can alter it
            reset_to_boot <= !boot_reset_fuse_n;
        end
    end
    // axi4-lite slave
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h00000000;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else begin
            s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_reg == `OFS_SPMCS ||
                    aw_addr_reg == `OFS_LOCKS) ? 2'b00 : 2'b10;
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case ({s_axi_araddr[7:2], 2'b00})
                    `OFS_SPMCS: s_axi_rdata <= {24'h000000, ctrl_reg[7:6], 1'b0,
                        ctrl_reg[4:0]};
                    `OFS_LOCKS: s_axi_rdata <= {24'h000000, lock_reg};
                    `OFS_FUSE: s_axi_rdata <= {31'h00000000, boot_reset_fuse_n};
                    `OFS_STATUS: s_axi_rdata <= {29'h00000000, state_reg};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// *** verification/boot_lock_sva.sv ***
// port-level assertions for the boot lock controller
`timescale 1ns/10ps
module boot_lock_sva (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire store_program_insn,
    input wire insn_target_halting,
    input wire exec_from_boot,
    input wire load_program_req,
    input wire vectors_in_boot,
    input wire global_irq_flag,
    input wire boot_reset_fuse_n,
    input wire flash_ready_irq,
    input wire cpu_halt,
    input wire concurrent_read_block,
    input wire load_program_deny,
    input wire store_program_deny,
    input wire irq_mask,
    input wire reset_to_boot,
    input wire [1:0] spm_op_start,
    input wire page_load_strobe
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
reg [7:0] ar_q;
// address kept so read data can be tied to its register
always @(posedge aclk) if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
property p_fuse; 1 |=> reset_to_boot == !$past(boot_reset_fuse_n); endproperty
a_fuse: assert property (p_fuse) else $error("reset vector wrong");
property p_irq; !global_irq_flag |=> !flash_ready_irq; endproperty
a_irq: assert property (p_irq) else $error("ready irq without global flag");
property p_load; !load_program_req |=> !load_program_deny; endproperty
a_load: assert property (p_load) else $error("load deny without request");
property p_store; !store_program_insn |=> !store_program_deny; endproperty
a_store: assert property (p_store) else $error("store deny without insn");
property p_mask; exec_from_boot == vectors_in_boot |=> !irq_mask; endproperty
a_mask: assert property (p_mask) else $error("irq masked in vector section");
property p_halt; spm_op_start != 2'b00 && insn_target_halting |-> ##[0:2] cpu_halt; endproperty
a_halt: assert property (p_halt) else $error("halting op kept cpu running");
property p_conc;
    spm_op_start != 2'b00 && !insn_target_halting |-> ##[0:2] concurrent_read_block;
endproperty
a_conc: assert property (p_conc) else $error("busy region left readable");
property p_rsvd; s_axi_rvalid && ar_q == 8'h00 |-> !s_axi_rdata[5]; endproperty
a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one");
c_halt: cover property (cpu_halt);
c_load: cover property (page_load_strobe);
c_deny: cover property (store_program_deny);
endmodule
bind boot_lock_self_program_ctrl boot_lock_sva boot_lock_sva_inst (.aclk(aclk),
    .aresetn(aresetn), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .store_program_insn(store_program_insn), .insn_target_halting(insn_target_halting),
    .exec_from_boot(exec_from_boot), .load_program_req(load_program_req),
    .vectors_in_boot(vectors_in_boot), .global_irq_flag(global_irq_flag),
    .boot_reset_fuse_n(boot_reset_fuse_n), .flash_ready_irq(flash_ready_irq),
    .cpu_halt(cpu_halt), .concurrent_read_block(concurrent_read_block),
    .load_program_deny(load_program_deny), .store_program_deny(store_program_deny),
    .irq_mask(irq_mask), .reset_to_boot(reset_to_boot), .spm_op_start(spm_op_start),
    .page_load_strobe(page_load_strobe));

// *** verification/boot_lock_self_program_ctrl_tb_top.sv ***
// self-checking bench for the boot lock controller
`timescale 1ns/10ps
module boot_lock_self_program_ctrl_tb_top;
reg aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, done = 0;
reg [7:0] awaddr = 8'h00, araddr = 8'h00, lkd = 8'h00, xld = 8'h00;
reg [31:0] wdata = 32'h0, rd = 32'h0;
reg spi = 0, tboot = 0, thalt = 0, efb = 0, lreq = 0, ltb = 0, vib = 0, gif = 0, fuse_n = 1;
reg cer = 0, xlw = 0, saw_pl = 0;
reg [1:0] rs = 2'b00;
wire awr, wr, bv, arr, rv, irq, halt, crb, ldeny, sdeny, imask, rtb, pls;
wire [1:0] bresp, rresp, ops;
wire [31:0] rdata;
integer n_fail = 0, compares = 0, cyc = 0;
always #4 aclk = ~aclk;
// op set above the default 16 cycles, and longer than a register read
boot_lock_self_program_ctrl #(.OP_CYCLES(20)) boot_lock_self_program_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .store_program_insn(spi), .insn_target_boot(tboot), .insn_target_halting(thalt),
    .insn_lock_data(lkd), .exec_from_boot(efb), .load_program_req(lreq),
    .load_target_boot(ltb), .vectors_in_boot(vib), .global_irq_flag(gif),
    .boot_reset_fuse_n(fuse_n), .chip_erase(cer), .ext_lock_write(xlw),
    .ext_lock_data(xld), .flash_ready_irq(irq), .cpu_halt(halt),
    .concurrent_read_block(crb), .load_program_deny(ldeny), .store_program_deny(sdeny),
    .irq_mask(imask), .reset_to_boot(rtb), .spm_op_start(ops), .page_load_strobe(pls));
task print_verdict;
    begin
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end
endtask
always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (pls) saw_pl <= 1;
    if (cyc == 3000) begin
        n_fail = n_fail + 1;
        print_verdict;
    end
end
task check(input [31:0] seen, input [31:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    end
endtask
task tick(input integer n);
    repeat (n) @(posedge aclk);
endtask
task wr32(input [7:0] a, input [31:0] d);
    begin
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awv <= 1;
        wv <= 1;
        bready <= 1;
        done = 0;
        while (!done) begin
            @(posedge aclk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
            done = bv;
        end
        bready <= 0;
    end
endtask
task rd32(input [7:0] a);
    begin
        @(posedge aclk);
        araddr <= a;
        arv <= 1;
        rready <= 1;
        done = 0;
        while (!done) begin
            @(posedge aclk);
            if (arr) arv <= 0;
            done = rv;
            rd = rdata;
            rs = rresp;
        end
        rready <= 0;
    end
endtask
// sel 0 pulses the store insn, sel 1 a load request; returns where the answer shows
task pulse(input sel);
    begin
        @(posedge aclk);
        if (sel) lreq <= 1;
        else spi <= 1;
        @(posedge aclk);
        lreq <= 0;
        spi <= 0;
        #1;
    end
endtask
task ext(input ce, input [7:0] d);
    begin
        @(posedge aclk);
        cer <= ce;
        xlw <= !ce;
        xld <= d;
        @(posedge aclk);
        cer <= 0;
        xlw <= 0;
    end
endtask
initial begin
    tick(4);
    aresetn <= 1;
    rd32(8'h00); check(rd, 32'h0);
    rd32(8'h04); check(rd, 32'hFF);
    rd32(8'h10); check(rs, 2'b10);
    wr32(8'h00, 32'hFF); rd32(8'h00); check(rd, 32'h80);
    wr32(8'h00, 32'h00);
    $display("test regs done");
    ext(0, 8'hFC); ext(0, 8'hFF); rd32(8'h04); check(rd, 32'hFC);
    efb <= 1;
    pulse(1); check(ldeny, 1);
    wr32(8'h00, 32'h05); pulse(0); check(sdeny, 1);
    ext(1, 8'h00); rd32(8'h04); check(rd, 32'hFF);
    ext(0, 8'hF9); pulse(1); check(ldeny, 1);
    efb <= 0;
    ltb <= 1;
    pulse(1); check(ldeny, 0);
    vib <= 1;
    tick(2); check(imask, 1);
    vib <= 0;
    efb <= 1;
    tboot <= 1;
    wr32(8'h00, 32'h05); pulse(0); check(sdeny, 1);
    ext(1, 8'h00);
    lkd <= 8'hF3;
    wr32(8'h00, 32'h09); pulse(0); rd32(8'h04); check(rd, 32'hF3);
    ext(1, 8'h00);
    tboot <= 0;
    $display("test locks done");
    wr32(8'h00, 32'h05); pulse(0); check(sdeny, 0);
    rd32(8'h00); check(rd, 32'h45); check(crb, 1);
    tick(24); rd32(8'h00); check(rd, 32'h40);
    wr32(8'h00, 32'h11); pulse(0); rd32(8'h00); check(rd, 32'h0);
    wr32(8'h00, 32'h05); pulse(0); tick(24);
    saw_pl <= 0;
    wr32(8'h00, 32'h01); pulse(0); rd32(8'h00); check(rd, 32'h0);
    check(saw_pl, 1);
    $display("test concurrent op done");
    thalt <= 1;
    wr32(8'h00, 32'h03); pulse(0); tick(2); check(halt, 1);
    tick(24); rd32(8'h00); check(rd, 32'h0);
    thalt <= 0;
    saw_pl <= 0;
    wr32(8'h00, 32'h01); tick(6); pulse(0); tick(2); check(saw_pl, 0);
    $display("test halting op done");
    wr32(8'h00, 32'h80);
    gif <= 1;
    tick(3); check(irq, 1);
    fuse_n <= 0;
    tick(3); check(rtb, 1);
    wr32(8'h08, 32'h0); tick(2); check(rtb, 1);
    $display("test irq fuse done");
    print_verdict;
end
endmodule
